// ---- hdl/tap_pkg.sv ----
// Shared constants and types for the test access port and its tester end
//
// Notes on behaviour
// - Enable bit zero disables port and pins.
// - Enabled port claims its pins from general use.
// - Five TMS-high rising edges force Test-Logic-Reset.
// - Device reset never resets TAP; tester does.
// - Synchronous machine with the sixteen standard states.
// - Serial transfer least significant bit first.
// - State moves on rising TCK, sampled TMS.
// - Starts in reset; tester forces reset first.
// - Test-Logic-Reset, TMS low goes Run-Test/Idle.
// - Idle, TMS high twice reaches Select-IR-Scan.
// - Select-IR, TMS low twice reaches Shift-IR.
// - Shift-IR takes one bit per edge, four total.
// - Entering a shift state enables TDO drive.
// - Shift-IR puts register bits on TDO, falling edges.
// - TDO released at first falling edge after shift.
// - Three edges: exit, update register, back to idle.
// - Exactly four signals: TCK, TMS, TDI, TDO.
// - Chain wiring: each TDO feeds next TDI only.
// - Instruction output changes only in Update-IR or reset.
// - Bypass bit is the path when nothing selected.

package tap_pkg;

    // --------------------------------------------------------------------
    // Controller states and tester phases
    // --------------------------------------------------------------------
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } tap_state_type;

    typedef enum logic [1:0] {
        PH_IDLE, PH_LOW, PH_HIGH
    } tap_phase_type;

    // --------------------------------------------------------------------
    // Instruction path
    // --------------------------------------------------------------------
    localparam int          IR_WIDTH   = 4;
    localparam logic [3:0]  IR_CAPTURE = 4'h1;
    // Bypass code after reset; value is arbitrary
    localparam logic [3:0]  IR_RESET   = 4'hF;

    // --------------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------------
    localparam int RESET_EDGES     = 5;
    localparam int CLK_PERIOD_NS   = 100;
    localparam int TCK_PERIOD_NS   = 800;
    localparam int TCK_HALF_CYCLES = TCK_PERIOD_NS / (2 * CLK_PERIOD_NS);

    // --------------------------------------------------------------------
    // Tester step word
    // --------------------------------------------------------------------
    localparam int STEP_WIDTH = 3;
    localparam int STEP_TDI   = 0;
    localparam int STEP_TMS   = 1;
    localparam int STEP_CAPT  = 2;
    localparam int FIFO_DEPTH = 8;

endpackage

// ---- hdl/tap_if.sv ----
// Four-wire test link between tester and device
`timescale 1ns/100ps
`default_nettype none

interface tap_if;
    logic      tck;
    logic      tms;
    logic      tdi;
    logic      tdo;
    logic      tdo_oe;
    wire logic tdo_line;

    // Released TDO floats high through a board pull-up
    assign tdo_line = tdo_oe ? tdo : 1'b1;

    modport dev  (input tck, input tms, input tdi,
                  output tdo, output tdo_oe);
    modport host (output tck, output tms, output tdi,
                  input tdo_line);
endinterface

`default_nettype wire

// ---- hdl/tap_dev.sv ----
// Device end: TAP controller, instruction path, bypass and TDO drive
`timescale 1ns/100ps
`default_nettype none

module tap_dev (
    input  wire logic                   clk_sys,
    input  wire logic                   reset_n,
    tap_if.dev                          link,
    input  wire logic                   test_port_enable_bit,
    input  wire logic                   dr_select,
    input  wire logic                   dr_tdo,
    output logic [tap_pkg::IR_WIDTH-1:0] instruction_reg,
    output logic                        pins_dedicated,
    output logic                        dr_capture,
    output logic                        dr_shift,
    output logic                        dr_update,
    output logic                        dr_tdi,
    output tap_pkg::tap_state_type      tap_state
);

    // --------------------------------------------------------------------
    // Standard state graph
    // --------------------------------------------------------------------
    function automatic tap_pkg::tap_state_type next_state(
        input tap_pkg::tap_state_type s,
        input logic                   tms
    );
        tap_pkg::tap_state_type r;
        r = s;
        unique case (s)
            tap_pkg::TLR:    r = tms ? tap_pkg::TLR    : tap_pkg::RTI;
            tap_pkg::RTI:    r = tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
            tap_pkg::SEL_DR: r = tms ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
            tap_pkg::CAP_DR: r = tms ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
            tap_pkg::SH_DR:  r = tms ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
            tap_pkg::EX1_DR: r = tms ? tap_pkg::UPD_DR : tap_pkg::PAU_DR;
            tap_pkg::PAU_DR: r = tms ? tap_pkg::EX2_DR : tap_pkg::PAU_DR;
            tap_pkg::EX2_DR: r = tms ? tap_pkg::UPD_DR : tap_pkg::SH_DR;
            tap_pkg::UPD_DR: r = tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
            tap_pkg::SEL_IR: r = tms ? tap_pkg::TLR    : tap_pkg::CAP_IR;
            tap_pkg::CAP_IR: r = tms ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
            tap_pkg::SH_IR:  r = tms ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
            tap_pkg::EX1_IR: r = tms ? tap_pkg::UPD_IR : tap_pkg::PAU_IR;
            tap_pkg::PAU_IR: r = tms ? tap_pkg::EX2_IR : tap_pkg::PAU_IR;
            tap_pkg::EX2_IR: r = tms ? tap_pkg::UPD_IR : tap_pkg::SH_IR;
            tap_pkg::UPD_IR: r = tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
        endcase
        return r;
    endfunction

    // --------------------------------------------------------------------
    // Pin synchronisers and TCK edge detection
    // --------------------------------------------------------------------
    logic [2:0]             tck_sq;
    logic [1:0]             tms_sq;
    logic [1:0]             tdi_sq;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tck_sq <= 3'h0;
            tms_sq <= 2'h0;
            tdi_sq <= 2'h0;
        end else begin
            tck_sq <= {tck_sq[1:0], link.tck};
            tms_sq <= {tms_sq[0], link.tms};
            tdi_sq <= {tdi_sq[0], link.tdi};
        end
    end

    wire logic              tck_rise;
    wire logic              tck_fall;
    wire logic              tms_s;
    wire logic              tdi_s;
    wire logic              en;

    assign tck_rise = tck_sq[1] & ~tck_sq[2];
    assign tck_fall = ~tck_sq[1] & tck_sq[2];
    assign tms_s    = tms_sq[1];
    assign tdi_s    = tdi_sq[1];
    // Disabled port ignores pin activity, except that dr_tdi still samples TDI on rising TCK
    assign en       = test_port_enable_bit;

    // --------------------------------------------------------------------
    // Controller state
    // --------------------------------------------------------------------
    // No device reset here on purpose: the tester owns this machine.
    // Holding the enable low is the only non-TMS way to define it.
    tap_pkg::tap_state_type state_q;
    tap_pkg::tap_state_type state_d;

    assign state_d = next_state(state_q, tms_s);

    always_ff @(posedge clk_sys) begin
        if (!en) begin
            state_q <= tap_pkg::TLR;
        end else if (tck_rise) begin
            state_q <= state_d;
        end
    end

    wire logic              in_tlr;
    wire logic              in_cap_ir;
    wire logic              in_sh_ir;
    wire logic              in_upd_ir;
    wire logic              in_cap_dr;
    wire logic              in_sh_dr;
    wire logic              in_upd_dr;

    assign in_tlr    = state_q == tap_pkg::TLR;
    assign in_cap_ir = state_q == tap_pkg::CAP_IR;
    assign in_sh_ir  = state_q == tap_pkg::SH_IR;
    assign in_upd_ir = state_q == tap_pkg::UPD_IR;
    assign in_cap_dr = state_q == tap_pkg::CAP_DR;
    assign in_sh_dr  = state_q == tap_pkg::SH_DR;
    assign in_upd_dr = state_q == tap_pkg::UPD_DR;

    // --------------------------------------------------------------------
    // Instruction shift stages, latched instruction and bypass bit
    // --------------------------------------------------------------------
    logic [tap_pkg::IR_WIDTH-1:0] ir_shift_q;
    logic [tap_pkg::IR_WIDTH-1:0] ir_q;
    logic                         bypass_q;

    always_ff @(posedge clk_sys) begin
        if (!en) begin
            ir_shift_q <= tap_pkg::IR_CAPTURE;
        end else if (tck_rise && in_cap_ir) begin
            ir_shift_q <= tap_pkg::IR_CAPTURE;
        end else if (tck_rise && in_sh_ir) begin
            // New bit enters at the top so bit 0 leaves first
            ir_shift_q <= {tdi_s, ir_shift_q[tap_pkg::IR_WIDTH-1:1]};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!en || in_tlr) begin
            ir_q <= tap_pkg::IR_RESET;
        end else if (tck_rise && in_upd_ir) begin
            ir_q <= ir_shift_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!en) begin
            bypass_q <= 1'b0;
        end else if (tck_rise && in_cap_dr) begin
            bypass_q <= 1'b0;
        end else if (tck_rise && in_sh_dr) begin
            bypass_q <= tdi_s;
        end
    end

    // --------------------------------------------------------------------
    // TDO drive, changed on falling TCK; cleared when disabled or in device reset
    // --------------------------------------------------------------------
    wire logic              dr_out;
    wire logic              shifting;
    wire logic              shift_bit;

    assign dr_out    = dr_select ? dr_tdo : bypass_q;
    assign shifting  = en && (in_sh_ir || in_sh_dr);
    assign shift_bit = in_sh_ir ? ir_shift_q[0] : dr_out;

    logic                   tdo_q;
    logic                   tdo_oe_q;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (!en) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe_q <= shifting;
            if (shifting) begin
                tdo_q <= shift_bit;
            end
        end
    end

    // --------------------------------------------------------------------
    // Data register strobes toward the chip side
    // --------------------------------------------------------------------
    // Strobes come a cycle after the detected edge; external data
    // registers have the rest of the half period to settle dr_tdo.
    logic                   dr_capture_q;
    logic                   dr_shift_q;
    logic                   dr_update_q;
    logic                   dr_tdi_q;
    logic                   pins_q;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dr_capture_q <= 1'b0;
            dr_shift_q   <= 1'b0;
            dr_update_q  <= 1'b0;
            dr_tdi_q     <= 1'b0;
            pins_q       <= 1'b0;
        end else begin
            dr_capture_q <= en && tck_rise && in_cap_dr;
            dr_shift_q   <= en && tck_rise && in_sh_dr;
            dr_update_q  <= en && tck_rise && in_upd_dr;
            if (tck_rise) begin
                dr_tdi_q <= tdi_s;
            end
            pins_q       <= en;
        end
    end

    assign link.tdo        = tdo_q;
    assign link.tdo_oe     = tdo_oe_q;
    assign instruction_reg = ir_q;
    assign pins_dedicated  = pins_q;
    assign dr_capture      = dr_capture_q;
    assign dr_shift        = dr_shift_q;
    assign dr_update       = dr_update_q;
    assign dr_tdi          = dr_tdi_q;
    assign tap_state       = state_q;

endmodule // tap_dev

`default_nettype wire

// ---- hdl/tap_host.sv ----
// Tester end: step FIFO and TCK generator that plays TMS/TDI steps
`timescale 1ns/100ps
`default_nettype none

module tap_fifo #(
    parameter int WIDTH = tap_pkg::STEP_WIDTH,
    parameter int DEPTH = tap_pkg::FIFO_DEPTH
) (
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    // Depth must be a power of two so pointers wrap naturally
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      count_q;

    wire logic        push;
    wire logic        pop;

    assign in_ready  = count_q != (AW+1)'(DEPTH);
    assign out_valid = count_q != '0;
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_q    <= '0;
            rd_q    <= '0;
            count_q <= '0;
        end else begin
            wr_q    <= push ? wr_q + 1'b1 : wr_q;
            rd_q    <= pop  ? rd_q + 1'b1 : rd_q;
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // tap_fifo

module tap_host #(
    parameter int TCK_HALF = tap_pkg::TCK_HALF_CYCLES
) (
    input  wire logic                         clk_sys,
    input  wire logic                         reset_n,
    tap_if.host                               link,
    input  wire logic                         step_valid,
    input  wire logic [tap_pkg::STEP_WIDTH-1:0] step_data,
    output logic                              step_ready,
    output logic                              res_valid,
    output logic                              res_bit
);

    // --------------------------------------------------------------------
    // Step queue; drained only between TCK cycles so it back-pressures
    // --------------------------------------------------------------------
    logic                              f_valid;
    logic [tap_pkg::STEP_WIDTH-1:0]    f_data;
    wire logic                         f_pop;

    tap_fifo #(
        .WIDTH (tap_pkg::STEP_WIDTH),
        .DEPTH (tap_pkg::FIFO_DEPTH)
    ) u_tap_fifo (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .in_valid  (step_valid),
        .in_data   (step_data),
        .in_ready  (step_ready),
        .out_valid (f_valid),
        .out_data  (f_data),
        .out_ready (f_pop)
    );

    // --------------------------------------------------------------------
    // TDO synchroniser
    // --------------------------------------------------------------------
    logic [1:0] tdo_sq;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tdo_sq <= 2'h3;
        end else begin
            tdo_sq <= {tdo_sq[0], link.tdo_line};
        end
    end

    // --------------------------------------------------------------------
    // TCK player
    // --------------------------------------------------------------------
    tap_pkg::tap_phase_type phase_q;
    logic [7:0]             cnt_q;
    logic [2:0]             rst_left_q;
    logic                   tck_q;
    logic                   tms_q;
    logic                   tdi_q;
    logic                   capt_q;
    logic                   res_valid_q;
    logic                   res_bit_q;

    wire logic              in_reset_seq;
    wire logic              start;
    wire logic              cnt_done;

    // Soft reset is replayed after every reset of this end
    assign in_reset_seq = rst_left_q != 3'h0;
    assign start        = phase_q == tap_pkg::PH_IDLE
                          && (in_reset_seq || f_valid);
    assign f_pop        = phase_q == tap_pkg::PH_IDLE
                          && !in_reset_seq && f_valid;
    assign cnt_done     = cnt_q == 8'h00;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            phase_q     <= tap_pkg::PH_IDLE;
            cnt_q       <= 8'h00;
            rst_left_q  <= 3'(tap_pkg::RESET_EDGES);
            tck_q       <= 1'b0;
            tms_q       <= 1'b1;
            tdi_q       <= 1'b0;
            capt_q      <= 1'b0;
            res_valid_q <= 1'b0;
            res_bit_q   <= 1'b0;
        end else begin
            res_valid_q <= 1'b0;
            unique case (phase_q)
                tap_pkg::PH_IDLE: begin
                    if (start) begin
                        // Steps are sent in queue order, LSB first by caller
                        tms_q   <= in_reset_seq
                                   | f_data[tap_pkg::STEP_TMS];
                        tdi_q   <= !in_reset_seq
                                   & f_data[tap_pkg::STEP_TDI];
                        capt_q  <= !in_reset_seq
                                   & f_data[tap_pkg::STEP_CAPT];
                        cnt_q   <= 8'(TCK_HALF - 1);
                        phase_q <= tap_pkg::PH_LOW;
                    end
                end
                tap_pkg::PH_LOW: begin
                    cnt_q <= cnt_q - 8'h01;
                    if (cnt_done) begin
                        tck_q   <= 1'b1;
                        cnt_q   <= 8'(TCK_HALF - 1);
                        phase_q <= tap_pkg::PH_HIGH;
                    end
                end
                tap_pkg::PH_HIGH: begin
                    cnt_q <= cnt_q - 8'h01;
                    if (cnt_done) begin
                        // Late sample: device TDO lags its falling edge
                        tck_q       <= 1'b0;
                        res_valid_q <= capt_q;
                        res_bit_q   <= tdo_sq[1];
                        if (in_reset_seq) begin
                            rst_left_q <= rst_left_q - 3'h1;
                        end
                        phase_q     <= tap_pkg::PH_IDLE;
                    end
                end
                default: phase_q <= tap_pkg::PH_IDLE;
            endcase
        end
    end

    assign link.tck  = tck_q;
    assign link.tms  = tms_q;
    assign link.tdi  = tdi_q;
    assign res_valid = res_valid_q;
    assign res_bit   = res_bit_q;

endmodule // tap_host

`default_nettype wire

// ---- hdl/tap_dev_unused_placeholder_none.sv ----
// Intentionally empty compile unit
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ---- test/tap_checker.sv ----
// Concurrent checks on the test link and controller state
`timescale 1ns/100ps
`default_nettype none

module tap_checker (
    input wire logic                         clk_sys,
    input wire logic                         reset_n,
    input wire logic                         tck,
    input wire logic                         tms,
    input wire logic                         tdo,
    input wire logic                         tdo_oe,
    input wire logic                         test_port_enable_bit,
    input wire logic [tap_pkg::IR_WIDTH-1:0] instruction_reg,
    input wire logic [3:0]                    tap_state
);
    // --------------------
    // Reference next state
    // --------------------
    // One nibble per state code, low TMS and high TMS
    localparam logic [63:0] NXT0 = 64'h1BDDBBA146644311;
    localparam logic [63:0] NXT1 = 64'h2FEFCC0287855920;
    logic        tck_q;
    logic  [3:0] exp_q;
    logic  [2:0] hi_q;
    wire         rise_w  = tck && !tck_q;
    wire  [63:0] tbl_w   = tms ? NXT1 : NXT0;
    wire   [3:0] exp_d   = tbl_w[{tap_state, 2'h0} +: 4];
    wire   [2:0] hi_d    = !tms ? 3'h0 : (hi_q == 3'h7 ? hi_q : hi_q + 3'h1);
    wire         shift_w = tap_state == tap_pkg::SH_IR
                        || tap_state == tap_pkg::SH_DR;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tck_q <= 1'b0;
            exp_q <= 4'h0;
            hi_q  <= 3'h0;
        end else begin
            tck_q <= tck;
            exp_q <= rise_w ? exp_d : exp_q;
            hi_q  <= rise_w ? hi_d : hi_q;
        end
    end

    // --------------------
    // Properties
    // --------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n || !test_port_enable_bit);

    next_state_a: assert property (
        rise_w |=> ##[1:5] tap_state == exp_q) else $error("bad next state");
    soft_reset_a: assert property (
        rise_w && tms && hi_q >= 3'h4 |-> ##[2:6] tap_state == tap_pkg::TLR)
        else $error("no soft reset");
    oe_on_a: assert property (
        $fell(tck) && shift_w |-> ##[1:6] tdo_oe) else $error("tdo not on");
    oe_off_a: assert property (
        $fell(tck) && !shift_w |-> ##[1:6] !tdo_oe) else $error("tdo kept");
    oe_shift_a: assert property (
        $rose(tdo_oe) |-> shift_w) else $error("tdo on outside shift");
    tdo_fall_a: assert property (
        $changed(tdo) |-> !tck) else $error("tdo moved with tck high");
    capture_a: assert property (
        $rose(tdo_oe) && tap_state == tap_pkg::SH_IR |-> tdo)
        else $error("capture bit wrong");
    ir_hold_a: assert property (
        $changed(instruction_reg) |-> $past(tap_state) == tap_pkg::UPD_IR
        || tap_state == tap_pkg::TLR) else $error("instruction moved");
    port_off_a: assert property (disable iff (!reset_n)
        !test_port_enable_bit [*2] |-> tap_state == tap_pkg::TLR && !tdo_oe)
        else $error("port not disabled");
    tck_high_a: assert property (
        $rose(tck) |-> tck [*3]) else $error("tck high too short");
    tms_hold_a: assert property (
        tck |-> $stable(tms)) else $error("tms moved with tck high");

    cover property (tap_state == tap_pkg::UPD_IR);
    cover property (tap_state == tap_pkg::UPD_DR);
    cover property (rise_w && tms && hi_q >= 3'h4);
endmodule // tap_checker

`default_nettype wire

// ---- test/tap_tb_top.sv ----
// Bench joining tester end and device end over the four-wire link
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
$display("[FAIL] %0t got %h exp %h", $time, a, e); end end

module tap_controller_instruction_path_tb_top;
    logic                           clk_sys;
    logic                           reset_n = 1'b0;
    logic                           test_port_enable_bit = 1'b0;
    logic                           dr_select = 1'b0;
    logic                           dr_tdo = 1'b0;
    logic                           step_valid = 1'b0;
    logic [tap_pkg::STEP_WIDTH-1:0] step_data = 3'h0;
    logic [tap_pkg::IR_WIDTH-1:0]   instruction_reg;
    logic                           pins_dedicated, dr_capture, dr_shift;
    logic                           dr_update, dr_tdi, step_ready;
    logic                           res_valid, res_bit;
    logic [3:0]                     got = 4'h0;
    logic [3:0]                     dr_got = 4'h0;
    tap_pkg::tap_state_type         tap_state;
    int errors = 0, checks = 0, cyc = 0, n_cap = 0, n_sh = 0, n_upd = 0;

    tap_if link_if ();
    tap_dev u_tap_dev (
        .clk_sys, .reset_n, .link(link_if), .test_port_enable_bit,
        .dr_select, .dr_tdo, .instruction_reg, .pins_dedicated, .dr_capture,
        .dr_shift, .dr_update, .dr_tdi, .tap_state);
    tap_host #(.TCK_HALF(4)) u_tap_host (
        .clk_sys, .reset_n, .link(link_if), .step_valid, .step_data,
        .step_ready, .res_valid, .res_bit);
    tap_checker u_tap_checker (
        .clk_sys, .reset_n, .tck(link_if.tck), .tms(link_if.tms),
        .tdo(link_if.tdo), .tdo_oe(link_if.tdo_oe),
        .test_port_enable_bit, .instruction_reg, .tap_state);

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Captured TDO bits enter at the top, so bit 0 is the first out
    always @(negedge clk_sys) begin
        cyc++;
        if (res_valid === 1'b1) got = {res_bit, got[3:1]};
        if (dr_shift === 1'b1) dr_got = {dr_tdi, dr_got[3:1]};
        n_cap += int'(dr_capture === 1'b1);
        n_sh += int'(dr_shift === 1'b1);
        n_upd += int'(dr_update === 1'b1);
        if (cyc == 20000) begin
            errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Valid stays up between pushes so queued steps go back to back
    task automatic step(input logic [2:0] s);
        @(negedge clk_sys);
        while (step_ready !== 1'b1) @(negedge clk_sys);
        step_valid = 1'b1;
        step_data = s;
        @(posedge clk_sys);
    endtask

    task automatic walk(input int n, input logic [7:0] m);
        for (int i = 0; i < n; i++) step({1'b0, m[i], 1'b0});
    endtask

    // Nine steps at most are pending; each lasts nine clocks
    task automatic idle();
        @(negedge clk_sys);
        step_valid = 1'b0;
        repeat (110) @(negedge clk_sys);
    endtask

    task automatic scan(input logic ir, input logic [3:0] v);
        walk(ir ? 5 : 4, ir ? 8'h06 : 8'h02);
        for (int i = 0; i < 4; i++) step({1'b1, i == 3, v[i]});
        walk(2, 8'h01);
        idle();
    endtask

    task automatic t_ir();
        for (int c = 0; c < 16; c++) begin
            scan(1'b1, 4'(c));
            `CHK(got, tap_pkg::IR_CAPTURE)
            `CHK(instruction_reg, 4'(c))
            `CHK(tap_state, tap_pkg::RTI)
            `CHK(link_if.tdo_line, 1'b1)
        end
        $display("test ir_scan done");
    endtask

    task automatic t_soft();
        walk(5, 8'h06);
        walk(4, 8'h0F);
        idle();
        `CHK(tap_state, tap_pkg::SEL_IR)
        walk(1, 8'h01);
        idle();
        `CHK(tap_state, tap_pkg::TLR)
        $display("test soft_reset done");
    endtask

    task automatic t_devrst();
        scan(1'b1, 4'h5);
        reset_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        `CHK(tap_state, tap_pkg::RTI)
        `CHK(instruction_reg, 4'h5)
        reset_n = 1'b1;
        idle();
        `CHK(tap_state, tap_pkg::TLR)
        $display("test device_reset done");
    endtask

    task automatic t_enable();
        scan(1'b1, 4'h3);
        `CHK(pins_dedicated, 1'b1)
        test_port_enable_bit = 1'b0;
        walk(1, 8'h00);
        idle();
        `CHK(tap_state, tap_pkg::TLR)
        `CHK(instruction_reg, tap_pkg::IR_RESET)
        `CHK(pins_dedicated, 1'b0)
        test_port_enable_bit = 1'b1;
        repeat (2) @(negedge clk_sys);
        `CHK(pins_dedicated, 1'b1)
        $display("test enable done");
    endtask

    task automatic t_fifo();
        for (int i = 0; i < 9; i++) step(3'h0);
        @(negedge clk_sys);
        `CHK(step_ready, 1'b0)
        step_valid = 1'b0;
        idle();
        `CHK(step_ready, 1'b1)
        `CHK(tap_state, tap_pkg::RTI)
        $display("test fifo done");
    endtask

    task automatic t_dr();
        scan(1'b0, 4'hA);
        `CHK(got, 4'h4)
        `CHK(dr_got, 4'hA)
        dr_select = 1'b1;
        dr_tdo = 1'b1;
        scan(1'b0, 4'h0);
        `CHK(got, 4'hF)
        `CHK(n_cap + n_sh * 16 + n_upd * 256, 32'h282)
        $display("test dr_scan done");
    endtask

    initial begin
        repeat (4) @(negedge clk_sys);
        test_port_enable_bit = 1'b1;
        repeat (4) @(negedge clk_sys);
        reset_n = 1'b1;
        idle();
        `CHK(tap_state, tap_pkg::TLR)
        t_ir();
        t_soft();
        t_devrst();
        t_enable();
        t_fifo();
        t_dr();
        summarize();
    end
endmodule // tap_controller_instruction_path_tb_top

`default_nettype wire
